/* File: jtd_defs.vh */
// Address map, field positions and fixed values of the transport deframer
`ifndef JTD_DEFS_VH
`define JTD_DEFS_VH

// Register addresses
`define JTD_ADDR_MODE 12'h110
`define JTD_ADDR_PHY_PD 12'h201
`define JTD_ADDR_PAGE 12'h300
`define JTD_ADDR_DID 12'h450
`define JTD_ADDR_BID 12'h451
`define JTD_ADDR_FIRST_LANE_IDENTIFIER 12'h452
`define JTD_ADDR_LM1 12'h453
`define JTD_ADDR_FM1 12'h454
`define JTD_ADDR_KM1 12'h455
`define JTD_ADDR_MM1 12'h456
`define JTD_ADDR_NM1 12'h457
`define JTD_ADDR_NPM1 12'h458
`define JTD_ADDR_SVER 12'h459
`define JTD_ADDR_HD 12'h45a
`define JTD_ADDR_DESKEW 12'h46c
`define JTD_ADDR_STATUS 12'h47f

// Per-page bank: slots 0..10 are 0x450..0x45a, slot 11 is deskew enable
`define JTD_BANK_SIZE 12
`define JTD_SLOT_DESKEW 11
`define JTD_SLOT_LM1 3
`define JTD_SLOT_FM1 4
`define JTD_SLOT_KM1 5
`define JTD_SLOT_MM1 6
`define JTD_SLOT_NM1 7
`define JTD_SLOT_NPM1 8
`define JTD_SLOT_SVER 9
`define JTD_SLOT_HD 10

// Field positions
`define JTD_MODE_MSB 4
`define JTD_DUAL_BIT 7
`define JTD_PAGE_BIT 2
`define JTD_HD_BIT 7
`define JTD_FIELD5_MSB 4
`define JTD_VER_MSB 7
`define JTD_VER_LSB 5

// Fixed link values
`define JTD_K_MINUS_ONE 8'h1f
`define JTD_HD_ONE 1'b1
`define JTD_VER_204A 3'h0
`define JTD_VER_204B 3'h1

// Octets per lane per parallel clock and block sizes
`define JTD_OCT_PER_PCLK 4
`define JTD_BLK_F3 12
`define JTD_BLK_F8 8
`define JTD_LANE_OCTETS 12
`define JTD_MAX_OCTETS 96
`define JTD_MAX_SAMPLES 64
`define JTD_SMP_W 16

// Mode table entry, sized fields: single ok, dual ok, L(4), M(3), F(4), S(4), NP(5)
`define JTD_MODE(vs, vd, l, m, f, s, np) {vs, vd, l, m, f, s, np}
`define JTD_ENTRY_W 22

`endif

/* File: jtd_deframer.v */
// Receive transport deframer: register file, mode check, lane control and sample unpacking
`timescale 1ns/100ps
`include "jtd_defs.vh"

module jtd_deframer #(
  parameter LANES = 8
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // Register access port
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  output reg reg_ack_r,
  // Descrambled lane data, four octets per lane per cycle, first octet in MSB
  input wire [LANES*32-1:0] lane_data,
  input wire lane_valid,
  input wire [LANES-1:0] lane_start,
  // Lane control
  output reg [LANES-1:0] phy_pd_r,
  output reg [2*LANES-1:0] lane_en_r,
  output reg [2*LANES-1:0] deskew_en_r,
  // Status
  output reg [1:0] cfg_ok_r,
  output reg run_r,
  // Samples, slot 0 in the MSBs, left justified to 16 bits
  output reg [`JTD_MAX_SAMPLES*`JTD_SMP_W-1:0] smp_data_r,
  output reg [6:0] smp_count_r,
  output reg smp_valid_r
);

  // Mode and page control
  reg [7:0] mode_r; // Mode select and dual-link flag
  reg [7:0] page_r; // Link page register
  reg [7:0] bank_r [0:2*`JTD_BANK_SIZE-1]; // Two pages of link settings
  // Lane octet collection
  reg [LANES*`JTD_MAX_OCTETS-1:0] buf_r;
  reg [LANES*`JTD_MAX_OCTETS-1:0] buf_nxt;
  reg [3:0] cnt_r; // Octets collected per lane
  reg [3:0] cnt_nxt;
  reg blk_done; // Block complete this cycle
  // Frame-ordered octets and unpacked samples
  reg [`JTD_MAX_OCTETS*8-1:0] fo;
  reg [`JTD_MAX_SAMPLES*`JTD_SMP_W-1:0] smp_nxt;
  reg [6:0] smp_cnt_nxt;
  // Working integers for the unpack loops
  integer i;
  integer o;
  integer q;
  integer ln;
  integer oc;
  integer fr;
  integer rm;
  integer k;
  integer b;
  integer p;
  integer nl;
  integer nf;
  integer nnp;
  integer nn;
  integer blk;
  integer tot;
  integer lr; // Lane index in the reorder loop
  integer cn; // Sample count before narrowing

  // Sized forms of the block and bank constants
  localparam [3:0] BLK_F3 = `JTD_BLK_F3;
  localparam [3:0] BLK_F8 = `JTD_BLK_F8;
  localparam [3:0] OCT_STEP = `JTD_OCT_PER_PCLK;
  localparam [3:0] SLOT_DSK = `JTD_SLOT_DESKEW;
  localparam [4:0] BANK_OFF = `JTD_BANK_SIZE;

  // Page bit picks link bank
  wire page_sel = page_r[`JTD_PAGE_BIT];
  wire dual = mode_r[`JTD_DUAL_BIT];
  wire [4:0] mode_sel = mode_r[`JTD_MODE_MSB:0];

  // Mode table lookup
  function [`JTD_ENTRY_W-1:0] jtd_mode_lut;
    input [4:0] md;
    begin
      case (md)
        5'h00: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd1, 3'd2, 4'd4, 4'd1, 5'd16);
        5'h01: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd2, 3'd4, 4'd4, 4'd1, 5'd16);
        5'h02: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd3, 3'd6, 4'd4, 4'd1, 5'd16);
        5'h03: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd2, 3'd2, 4'd2, 4'd1, 5'd16);
        5'h04: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd4, 3'd4, 4'd2, 4'd1, 5'd16);
        5'h05: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd1, 3'd2, 4'd3, 4'd1, 5'd12);
        5'h06: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd2, 3'd4, 4'd3, 4'd1, 5'd12);
        5'h07: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd1, 3'd4, 4'd8, 4'd1, 5'd16);
        5'h08: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd4, 3'd2, 4'd1, 4'd1, 5'd16);
        5'h09: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd4, 3'd2, 4'd2, 4'd2, 5'd16);
        5'h0a: jtd_mode_lut = `JTD_MODE(1'b1, 1'b0, 4'd8, 3'd2, 4'd1, 4'd2, 5'd16);
        5'h0b: jtd_mode_lut = `JTD_MODE(1'b1, 1'b0, 4'd8, 3'd2, 4'd2, 4'd4, 5'd16);
        5'h0c: jtd_mode_lut = `JTD_MODE(1'b1, 1'b0, 4'd8, 3'd2, 4'd3, 4'd8, 5'd12);
        5'h12: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd4, 3'd1, 4'd1, 4'd2, 5'd16);
        5'h13: jtd_mode_lut = `JTD_MODE(1'b1, 1'b1, 4'd4, 3'd1, 4'd2, 4'd4, 5'd16);
        5'h14: jtd_mode_lut = `JTD_MODE(1'b1, 1'b0, 4'd8, 3'd1, 4'd1, 4'd4, 5'd16);
        5'h15: jtd_mode_lut = `JTD_MODE(1'b1, 1'b0, 4'd8, 3'd1, 4'd2, 4'd8, 5'd16);
        default: jtd_mode_lut = {`JTD_ENTRY_W{1'b0}};
      endcase
    end
  endfunction

  // Decoded mode parameters
  wire [`JTD_ENTRY_W-1:0] ent = jtd_mode_lut(mode_sel);
  wire mode_ok = dual ? ent[20] : ent[21];
  wire [3:0] m_l = ent[19:16];
  wire [2:0] m_m = ent[15:13];
  wire [3:0] m_f = ent[12:9];
  wire [3:0] m_s = ent[8:5];
  wire [4:0] m_np = ent[4:0];
  // All table modes have N equal to NP
  wire [4:0] m_n = ent[4:0];

  // Check one page against the selected mode
  function jtd_page_ok;
    input [7:0] lm1;
    input [7:0] fm1;
    input [7:0] km1;
    input [7:0] mm1;
    input [7:0] nm1;
    input [7:0] npm1;
    input [7:0] sver;
    input [7:0] hd;
    input [3:0] l;
    input [2:0] m;
    input [3:0] f;
    input [3:0] s;
    input [4:0] np;
    input [4:0] n;
    begin
      jtd_page_ok = (lm1[`JTD_FIELD5_MSB:0] == l - 4'h1) &&
        (fm1 == {4'h0, f - 4'h1}) &&
        (km1[`JTD_FIELD5_MSB:0] == `JTD_K_MINUS_ONE) &&
        (mm1 == {5'h00, m - 3'h1}) &&
        (nm1[`JTD_FIELD5_MSB:0] == n - 5'h01) &&
        (npm1[`JTD_FIELD5_MSB:0] == np - 5'h01) &&
        (sver[`JTD_FIELD5_MSB:0] == {1'b0, s - 4'h1}) &&
        ((sver[`JTD_VER_MSB:`JTD_VER_LSB] == `JTD_VER_204A) ||
         (sver[`JTD_VER_MSB:`JTD_VER_LSB] == `JTD_VER_204B)) &&
        (hd[`JTD_HD_BIT] == `JTD_HD_ONE);
    end
  endfunction

  // Per-link configuration check, second link only counts in dual mode
  wire ok0 = mode_ok && jtd_page_ok(bank_r[`JTD_SLOT_LM1], bank_r[`JTD_SLOT_FM1],
    bank_r[`JTD_SLOT_KM1], bank_r[`JTD_SLOT_MM1], bank_r[`JTD_SLOT_NM1],
    bank_r[`JTD_SLOT_NPM1], bank_r[`JTD_SLOT_SVER], bank_r[`JTD_SLOT_HD],
    m_l, m_m, m_f, m_s, m_np, m_n);
  wire ok1 = dual && mode_ok && jtd_page_ok(bank_r[`JTD_BANK_SIZE+`JTD_SLOT_LM1],
    bank_r[`JTD_BANK_SIZE+`JTD_SLOT_FM1], bank_r[`JTD_BANK_SIZE+`JTD_SLOT_KM1],
    bank_r[`JTD_BANK_SIZE+`JTD_SLOT_MM1], bank_r[`JTD_BANK_SIZE+`JTD_SLOT_NM1],
    bank_r[`JTD_BANK_SIZE+`JTD_SLOT_NPM1], bank_r[`JTD_BANK_SIZE+`JTD_SLOT_SVER],
    bank_r[`JTD_BANK_SIZE+`JTD_SLOT_HD], m_l, m_m, m_f, m_s, m_np, m_n);

  // Lane mask from mode lane count
  // Shifting past the top bit wraps to all ones for a full lane set
  wire [LANES-1:0] lmask = ({{(LANES-1){1'b0}}, 1'b1} << m_l) - {{(LANES-1){1'b0}}, 1'b1};
  // Octets per lane per block: whole frames per block
  wire [3:0] blk_len = (m_f == 4'd3) ? BLK_F3 : (m_f == 4'd8) ? BLK_F8 : OCT_STEP;
  // Lanes whose start marker gates the deskewed start
  // Lanes outside the deskew mask are not waited on
  wire [LANES-1:0] dsk_need = lmask & bank_r[`JTD_SLOT_DESKEW][LANES-1:0];
  wire start_ok = ((lane_start & dsk_need) == dsk_need);

  // Bank slot of an address in the per-link range, or none
  reg slot_hit;
  reg [3:0] slot;
  always @* begin
    slot_hit = 1'b1;
    slot = 4'h0;
    if (reg_addr >= `JTD_ADDR_DID && reg_addr <= `JTD_ADDR_HD) begin
      slot = reg_addr[3:0];
    end else if (reg_addr == `JTD_ADDR_DESKEW) begin
      slot = SLOT_DSK;
    end else begin
      slot_hit = 1'b0;
    end
  end
  wire [4:0] bidx = (page_sel ? BANK_OFF : 5'd0) + {1'b0, slot};

  // Register writes and readback
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= 8'h00;
      page_r <= 8'h00;
      phy_pd_r <= {LANES{1'b0}};
      reg_rdata_r <= 8'h00;
      reg_ack_r <= 1'b0;
      for (i = 0; i < 2*`JTD_BANK_SIZE; i = i + 1) begin
        bank_r[i] <= 8'h00;
      end
    end else if (ce) begin
      reg_ack_r <= reg_wr | reg_rd;
      if (reg_wr) begin
        // Write decode
        case (reg_addr)
          `JTD_ADDR_MODE: mode_r <= reg_wdata;
          `JTD_ADDR_PHY_PD: phy_pd_r <= reg_wdata[LANES-1:0];
          `JTD_ADDR_PAGE: page_r <= reg_wdata;
          default: begin
            if (slot_hit) begin
              bank_r[bidx] <= reg_wdata;
            end
          end
        endcase
      end
      if (reg_rd) begin
        // Read decode, unmapped reads zero
        case (reg_addr)
          `JTD_ADDR_MODE: reg_rdata_r <= mode_r;
          `JTD_ADDR_PHY_PD: reg_rdata_r <= phy_pd_r;
          `JTD_ADDR_PAGE: reg_rdata_r <= page_r;
          `JTD_ADDR_STATUS: reg_rdata_r <= {5'h00, run_r, cfg_ok_r};
          default: reg_rdata_r <= slot_hit ? bank_r[bidx] : 8'h00;
        endcase
      end
    end
  end

  // Lane enables, deskew enables and configuration status
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lane_en_r <= {2*LANES{1'b0}};
      deskew_en_r <= {2*LANES{1'b0}};
      cfg_ok_r <= 2'b00;
    end else if (ce) begin
      cfg_ok_r <= {ok1, ok0};
      lane_en_r <= {(ok1 ? lmask : {LANES{1'b0}}), (ok0 ? lmask : {LANES{1'b0}})};
      deskew_en_r <= {(ok1 ? lmask & bank_r[`JTD_BANK_SIZE+`JTD_SLOT_DESKEW][LANES-1:0] : {LANES{1'b0}}),
        (ok0 ? dsk_need : {LANES{1'b0}})};
    end
  end

  // Collect four octets per lane per cycle into the block buffer
  always @* begin
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    blk_done = 1'b0;
    ln = 0;
    q = 0;
    if (lane_valid) begin
      for (ln = 0; ln < LANES; ln = ln + 1) begin
        for (q = 0; q < `JTD_OCT_PER_PCLK; q = q + 1) begin
          // Octet q of this beat lands after the octets already held
          buf_nxt[ln*`JTD_MAX_OCTETS + `JTD_MAX_OCTETS - 1 - 8*(cnt_r + q) -: 8] =
            lane_data[ln*32 + 31 - 8*q -: 8];
        end
      end
      cnt_nxt = cnt_r + OCT_STEP;
      if (cnt_nxt >= blk_len) begin
        blk_done = 1'b1;
        cnt_nxt = 4'h0;
      end
    end
  end

  // Reorder lane octets into frame order, then cut samples
  always @* begin
    fo = {`JTD_MAX_OCTETS*8{1'b0}};
    smp_nxt = {`JTD_MAX_SAMPLES*`JTD_SMP_W{1'b0}};
    nl = m_l;
    nf = m_f;
    nnp = m_np;
    nn = m_n;
    blk = blk_len;
    tot = nl * blk;
    // Loop temporaries start defined so no latch is inferred
    fr = 0;
    rm = 0;
    lr = 0;
    oc = 0;
    p = 0;
    cn = 0;
    // Frame j holds lane 0 octets, then lane 1, each F octets
    for (o = 0; o < `JTD_MAX_OCTETS; o = o + 1) begin
      if (o < tot && nf != 0) begin
        fr = o / (nl * nf);
        rm = o % (nl * nf);
        lr = rm / nf;
        oc = fr * nf + rm % nf;
        fo[`JTD_MAX_OCTETS*8 - 1 - 8*o -: 8] =
          buf_nxt[lr*`JTD_MAX_OCTETS + `JTD_MAX_OCTETS - 1 - 8*oc -: 8];
      end
    end
    // Samples sit back to back, MSB first; low NP-N bits dropped
    for (k = 0; k < `JTD_MAX_SAMPLES; k = k + 1) begin
      for (b = 0; b < `JTD_SMP_W; b = b + 1) begin
        p = k * nnp + b;
        if (b < nn && p < tot * 8) begin
          smp_nxt[(`JTD_MAX_SAMPLES - k)*`JTD_SMP_W - 1 - b] = fo[`JTD_MAX_OCTETS*8 - 1 - p];
        end
      end
    end
    cn = (nnp != 0) ? (tot * 8 / nnp) : 0;
    smp_cnt_nxt = cn[6:0];
  end

  // Run control, octet count, sample output
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      cnt_r <= 4'h0;
      buf_r <= {LANES*`JTD_MAX_OCTETS{1'b0}};
      smp_data_r <= {`JTD_MAX_SAMPLES*`JTD_SMP_W{1'b0}};
      smp_count_r <= 7'h00;
      smp_valid_r <= 1'b0;
    end else if (ce) begin
      smp_valid_r <= 1'b0;
      if (!ok0) begin
        // Unsupported setup holds the deframer off
        run_r <= 1'b0;
        cnt_r <= 4'h0;
      end else if (!run_r) begin
        // Deskewed start once all marked lanes present their marker
        if (lane_valid && start_ok) begin
          run_r <= 1'b1;
          buf_r <= buf_nxt;
          cnt_r <= cnt_nxt;
          if (blk_done) begin
            smp_data_r <= smp_nxt;
            smp_count_r <= smp_cnt_nxt;
            smp_valid_r <= 1'b1;
          end
        end
      end else begin
        // Running: collect and emit whole blocks
        buf_r <= buf_nxt;
        cnt_r <= cnt_nxt;
        if (blk_done) begin
          smp_data_r <= smp_nxt;
          smp_count_r <= smp_cnt_nxt;
          smp_valid_r <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: jtd_tx_model.sv */
// Transmitter model that packs samples into lane octets
`timescale 1ns/100ps
module jtd_tx_model (
  // Clock
  input wire clk,
  // Lane side
  output logic [255:0] lane_data,
  output logic lane_valid,
  output logic [7:0] lane_start
);
  logic [15:0] smp [0:63]; // Samples to send, left justified
  logic [1023:0] bits; // Block stream, first bit in MSB

  // Lanes idle at time zero
  initial begin
    lane_data = '0;
    lane_valid = 1'b0;
    lane_start = 8'h00;
  end

  // One block of nsmp samples over l lanes, f octets per frame per lane
  task automatic send(input int l, input int f, input int np, input int nsmp, input bit start);
    int blk, off, j, o;
    blk = (f == 3) ? 12 : (f == 8) ? 8 : 4;
    bits = '0;
    for (int k = 0; k < nsmp; k++) begin
      for (int b = 0; b < np; b++) begin
        bits[1023 - k * np - b] = smp[k][15 - b];
      end
    end
    for (int c = 0; c < blk / 4; c++) begin
      @(negedge clk);
      for (int i = 0; i < l; i++) begin
        for (int p = 0; p < 4; p++) begin
          o = c * 4 + p;
          j = o / f;
          off = (j * f * l + i * f + o % f) * 8;
          lane_data[32 * i + 31 - 8 * p -: 8] = bits[1023 - off -: 8];
        end
      end
      lane_valid = 1'b1;
      lane_start = (start && c == 0) ? 8'hff : 8'h00;
    end
    @(negedge clk);
    lane_valid = 1'b0;
    lane_start = 8'h00;
    // Released lanes must not keep showing old data
    lane_data = ~lane_data;
  endtask
endmodule

/* File: jtd_deframer_monitor.sv */
// Port checker of the transport deframer
`timescale 1ns/100ps
module jtd_deframer_monitor #(
  parameter LANES = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // Register port
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_r,
  input wire reg_ack_r,
  // Lanes, control and status
  input wire lane_valid,
  input wire [LANES-1:0] lane_start,
  input wire [LANES-1:0] phy_pd_r,
  input wire [2*LANES-1:0] lane_en_r,
  input wire [2*LANES-1:0] deskew_en_r,
  input wire [1:0] cfg_ok_r,
  input wire run_r,
  input wire smp_valid_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Register request taken
  sequence s_req;
    ce && (reg_wr || reg_rd);
  endsequence
  // Start beat on a settled valid setup, every deskewed lane marked
  sequence s_start;
    ce && lane_valid && !run_r && cfg_ok_r[0] && !$past(reg_wr)
      && ((lane_start & deskew_en_r[LANES-1:0]) == deskew_en_r[LANES-1:0]);
  endsequence
  AST_ACK: assert property (s_req |=> reg_ack_r)
    else $error("register request not acknowledged");
  AST_ACK_CAUSE: assert property (reg_ack_r |-> $past(ce && (reg_wr || reg_rd)))
    else $error("acknowledge without request");
  AST_RDATA_HOLD: assert property (!$stable(reg_rdata_r) |-> $past(ce && reg_rd))
    else $error("read data changed without read");
  AST_PD: assert property (s_req ##0 reg_wr && reg_addr == 12'h201 |=> phy_pd_r == $past(reg_wdata[LANES-1:0]))
    else $error("power down does not follow write");
  AST_START: assert property (s_start |=> run_r)
    else $error("deframer did not start");
  AST_RUN_CFG: assert property (run_r |-> cfg_ok_r[0])
    else $error("running on invalid setup");
  AST_SMP_CFG: assert property (smp_valid_r |-> cfg_ok_r[0] && $past(ce && lane_valid))
    else $error("samples without valid beat");
  AST_DESKEW: assert property (deskew_en_r == (deskew_en_r & lane_en_r))
    else $error("deskew on disabled lane");
endmodule

bind jtd_deframer jtd_deframer_monitor #(.LANES(LANES)) u_jtd_deframer_monitor (.clk, .rst, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .reg_ack_r, .lane_valid, .lane_start, .phy_pd_r, .lane_en_r,
  .deskew_en_r, .cfg_ok_r, .run_r, .smp_valid_r);

/* File: jesd204b_transport_deframer_tb.sv */
// Self-checking testbench of the transport deframer
`timescale 1ns/100ps
module jesd204b_transport_deframer_tb;
  // Clock, reset and register port
  logic clk;
  logic rst;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic ce;
  wire [7:0] reg_rdata_r;
  wire reg_ack_r;
  // Lanes, control, status and samples
  wire [255:0] lane_data;
  wire lane_valid;
  wire [7:0] lane_start;
  wire [7:0] phy_pd_r;
  wire [15:0] lane_en_r;
  wire [15:0] deskew_en_r;
  wire [1:0] cfg_ok_r;
  wire run_r;
  wire [1023:0] smp_data_r;
  wire [6:0] smp_count_r;
  wire smp_valid_r;
  int bad_count = 0;
  int n_tests = 0;
  // Mode table rows: mode, L, M, F, S, NP
  int tbl [17][6] = '{'{0,1,2,4,1,16}, '{1,2,4,4,1,16}, '{2,3,6,4,1,16}, '{3,2,2,2,1,16}, '{4,4,4,2,1,16},
    '{5,1,2,3,1,12}, '{6,2,4,3,1,12}, '{7,1,4,8,1,16}, '{8,4,2,1,1,16}, '{9,4,2,2,2,16}, '{10,8,2,1,2,16},
    '{11,8,2,2,4,16}, '{12,8,2,3,8,12}, '{18,4,1,1,2,16}, '{19,4,1,2,4,16}, '{20,8,1,1,4,16}, '{21,8,1,2,8,16}};
  logic [11:0] regs [16] = '{12'h110, 12'h201, 12'h300, 12'h450, 12'h451, 12'h452, 12'h453, 12'h454,
    12'h455, 12'h456, 12'h457, 12'h458, 12'h459, 12'h45a, 12'h46c, 12'h47f};

  jtd_deframer #(.LANES(8)) u_jtd_deframer (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .reg_ack_r, .lane_data, .lane_valid, .lane_start, .phy_pd_r, .lane_en_r, .deskew_en_r,
    .cfg_ok_r, .run_r, .smp_data_r, .smp_count_r, .smp_valid_r);
  jtd_tx_model u_jtd_tx_model (.clk, .lane_data, .lane_valid, .lane_start);

  // Clock of 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One register access, strobe for one cycle
  task automatic acc(input logic [11:0] a, input logic [7:0] d, input bit w);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chk(16'(reg_ack_r), 16'h0001);
    @(negedge clk);
  endtask

  // Register read and compare
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 1'b0);
    chk(16'(reg_rdata_r), 16'(exp));
  endtask

  // Program the link of the selected page for table row r
  task automatic cfg(input int r, input bit dual);
    acc(12'h110, 8'(tbl[r][0] + (dual ? 128 : 0)), 1'b1);
    acc(12'h453, 8'(tbl[r][1] - 1), 1'b1);
    acc(12'h454, 8'(tbl[r][3] - 1), 1'b1);
    acc(12'h455, 8'h1f, 1'b1);
    acc(12'h456, 8'(tbl[r][2] - 1), 1'b1);
    acc(12'h457, 8'(tbl[r][5] - 1), 1'b1);
    acc(12'h458, 8'(tbl[r][5] - 1), 1'b1);
    acc(12'h459, 8'(32 + tbl[r][4] - 1), 1'b1);
    acc(12'h45a, 8'h80, 1'b1);
  endtask

  // Send one block for table row r and compare the samples
  task automatic stream(input int r, input bit start);
    logic [15:0] mask;
    int n;
    n = tbl[r][1] * ((tbl[r][3] == 3) ? 12 : (tbl[r][3] == 8) ? 8 : 4) * 8 / tbl[r][5];
    mask = 16'hffff << (16 - tbl[r][5]);
    for (int k = 0; k < n; k++)
      u_jtd_tx_model.smp[k] = 16'(k * 16'h1357 + r * 16'h0b1d + (start ? 16'h8000 : 16'h0000));
    u_jtd_tx_model.send(tbl[r][1], tbl[r][3], tbl[r][5], n, start);
    chk(16'(smp_valid_r), 16'h0001);
    chk(16'(smp_count_r), 16'(n));
    for (int k = 0; k < n; k++)
      chk(smp_data_r[1023 - 16 * k -: 16], u_jtd_tx_model.smp[k] & mask);
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    wrap_up;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(16'(phy_pd_r), 16'h0000);
    foreach (regs[i])
      rchk(regs[i], 8'h00);
    acc(12'h123, 8'hff, 1'b1);
    rchk(12'h123, 8'h00);
    acc(12'h201, 8'ha5, 1'b1);
    chk(16'(phy_pd_r), 16'h00a5);
    rchk(12'h201, 8'ha5);
    // Write ignored and no acknowledge while the clock enable is low
    @(negedge clk);
    ce = 1'b0;
    reg_addr = 12'h201;
    reg_wdata = 8'h00;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    ce = 1'b1;
    chk(16'(reg_ack_r), 16'h0000);
    chk(16'(phy_pd_r), 16'h00a5);
    acc(12'h450, 8'h3c, 1'b1);
    acc(12'h452, 8'h1b, 1'b1);
    rchk(12'h450, 8'h3c);
    rchk(12'h452, 8'h1b);
    // Every single-link mode accepted with its lanes enabled
    for (int r = 0; r < 17; r++) begin
      cfg(r, 1'b0);
      chk(16'(cfg_ok_r), 16'h0001);
      chk(lane_en_r, 16'((1 << tbl[r][1]) - 1));
    end
    // Refused settings
    cfg(12, 1'b1);
    chk(16'(cfg_ok_r), 16'h0000);
    acc(12'h110, 8'h0d, 1'b1);
    chk(16'(cfg_ok_r), 16'h0000);
    cfg(8, 1'b0);
    acc(12'h455, 8'h1e, 1'b1);
    chk(16'(cfg_ok_r), 16'h0000);
    acc(12'h455, 8'h1f, 1'b1);
    acc(12'h45a, 8'h7f, 1'b1);
    chk(16'(cfg_ok_r), 16'h0000);
    acc(12'h45a, 8'h80, 1'b1);
    acc(12'h459, 8'h40, 1'b1);
    chk(16'(cfg_ok_r), 16'h0000);
    acc(12'h459, 8'h00, 1'b1);
    chk(16'(cfg_ok_r), 16'h0001);
    acc(12'h46c, 8'h0f, 1'b1);
    chk(deskew_en_r, 16'h000f);
    // Streaming, four lanes then twelve-bit three-octet frames
    stream(8, 1'b1);
    chk(16'(run_r), 16'h0001);
    stream(8, 1'b0);
    rchk(12'h47f, 8'h05);
    cfg(5, 1'b0);
    chk(deskew_en_r, 16'h0001);
    stream(5, 1'b1);
    // Dual link with banked per-page settings
    cfg(8, 1'b1);
    acc(12'h300, 8'h04, 1'b1);
    cfg(8, 1'b1);
    acc(12'h46c, 8'h05, 1'b1);
    chk(16'(cfg_ok_r), 16'h0003);
    chk(lane_en_r, 16'h0f0f);
    chk(deskew_en_r, 16'h050f);
    acc(12'h300, 8'h00, 1'b1);
    rchk(12'h46c, 8'h0f);
    wrap_up;
  end
endmodule
